// ==== rtl/xscm_unit.sv ====
// The implementer's own choices: the APB register port and the address map.
`timescale 1ns/100ps

module xscm_unit #(
  parameter int ADDR_W = 32
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              ce,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   mem_req,
  output logic                   mem_we,
  output logic                   mem_lock,
  output logic      [ADDR_W-1:0] mem_addr,
  output logic      [31:0]       mem_wdata,
  input  wire logic [31:0]       mem_rdata,
  input  wire logic              mem_ack,
  output logic                   busy
);

  // ==========================================================
  // Elaboration checks
  generate
    if (ADDR_W < 1 || ADDR_W > 32) begin : g_bad_addr_w
      $error("xscm_unit: ADDR_W must lie between 1 and 32");
    end
    // Package fields must fit their words and stay apart
    if (xscm_pkg::CTRL_COND_LSB < xscm_pkg::CTRL_OP_LSB + 2) begin : g_bad_ctrl_op
      $error("xscm_unit: operation and condition fields overlap");
    end
    if (xscm_pkg::CTRL_MEM_BIT < xscm_pkg::CTRL_COND_LSB + 4) begin : g_bad_ctrl_mem
      $error("xscm_unit: condition field and memory select overlap");
    end
    if (xscm_pkg::CTRL_MEM_BIT > 31) begin : g_bad_ctrl_w
      $error("xscm_unit: memory select lies outside the control word");
    end
    if (xscm_pkg::CMD_START_BIT > 31) begin : g_bad_cmd_w
      $error("xscm_unit: start bit lies outside the command word");
    end
    if (xscm_pkg::ST_LOCK_BIT > 31) begin : g_bad_st_w
      $error("xscm_unit: lock bit lies outside the status word");
    end
    if (xscm_pkg::ST_BUSY_BIT == xscm_pkg::ST_DONE_BIT) begin : g_bad_st_bits
      $error("xscm_unit: busy and done share a status bit");
    end
    if (xscm_pkg::CARRY_BIT > 31) begin : g_bad_carry
      $error("xscm_unit: carry flag lies outside the flag word");
    end
    if (xscm_pkg::PARITY_BIT > 31) begin : g_bad_parity
      $error("xscm_unit: parity flag lies outside the flag word");
    end
    if (xscm_pkg::ZERO_BIT > 31) begin : g_bad_zero
      $error("xscm_unit: zero flag lies outside the flag word");
    end
    if (xscm_pkg::SIGN_BIT > 31) begin : g_bad_sign
      $error("xscm_unit: sign flag lies outside the flag word");
    end
    if (xscm_pkg::OVERFLOW_BIT > 31) begin : g_bad_overflow
      $error("xscm_unit: overflow flag lies outside the flag word");
    end
    if (xscm_pkg::CARRY_BIT == xscm_pkg::ZERO_BIT) begin : g_bad_flag_bits
      $error("xscm_unit: carry and zero share a flag bit");
    end
  endgenerate

  xscm_pkg::xscm_state_t r;
  xscm_pkg::xscm_state_t next_r;

  // ==========================================================
  // Byte reverse datapath, one lane per generate step
  logic [31:0] reversed;

  genvar lane;
  generate
    for (lane = 0; lane < 4; lane++) begin : g_rev
      // Lane k takes lane 3-k: 0<->3 and 1<->2, an involution
      assign reversed[lane*8 +: 8] = r.opa[(3-lane)*8 +: 8];
    end
  endgenerate

  // ==========================================================
  // Condition evaluation
  xscm_pkg::xscm_flags_t flags_view;
  logic                  cond_hit;

  assign flags_view.carry_flag    = r.flags[xscm_pkg::CARRY_BIT];
  assign flags_view.zero_flag     = r.flags[xscm_pkg::ZERO_BIT];
  assign flags_view.parity_flag   = r.flags[xscm_pkg::PARITY_BIT];
  assign flags_view.sign_flag     = r.flags[xscm_pkg::SIGN_BIT];
  assign flags_view.overflow_flag = r.flags[xscm_pkg::OVERFLOW_BIT];

  xscm_cond_eval u_cond (
    .flags     (flags_view),
    .cond      (r.cond),
    .cond_true (cond_hit)
  );

  // ==========================================================
  // Bus decode
  logic        acc_phase;
  logic        wr_en;
  logic        mapped;
  logic        is_busy;
  logic [31:0] status_word;
  logic [31:0] ctrl_word;
  logic [31:0] read_mux;

  assign is_busy   = (r.fsm != xscm_pkg::ST_IDLE);
  assign acc_phase = psel & penable & ce & r.captured;
  assign wr_en     = acc_phase & pwrite & ~r.pslverr;

  always_comb begin
    ctrl_word = 32'h0000_0000;
    ctrl_word[xscm_pkg::CTRL_OP_LSB +: 2]   = r.op;
    ctrl_word[xscm_pkg::CTRL_COND_LSB +: 4] = r.cond;
    ctrl_word[xscm_pkg::CTRL_MEM_BIT]       = r.mem_sel;
    status_word = 32'h0000_0000;
    status_word[xscm_pkg::ST_BUSY_BIT]  = is_busy;
    status_word[xscm_pkg::ST_DONE_BIT]  = r.done;
    status_word[xscm_pkg::ST_COND_BIT]  = r.cond_true;
    status_word[xscm_pkg::ST_MOVED_BIT] = r.moved;
    status_word[xscm_pkg::ST_LOCK_BIT]  = r.mem.lock;
  end

  always_comb begin
    mapped   = 1'b1;
    read_mux = 32'h0000_0000;
    case (paddr)
      xscm_pkg::OFF_CTRL:     read_mux = ctrl_word;
      xscm_pkg::OFF_CMD:      read_mux = 32'h0000_0000;
      xscm_pkg::OFF_STATUS:   read_mux = status_word;
      xscm_pkg::OFF_OPA:      read_mux = r.opa;
      xscm_pkg::OFF_OPB:      read_mux = r.opb;
      xscm_pkg::OFF_FLAGS:    read_mux = r.flags;
      xscm_pkg::OFF_MEM_ADDR: read_mux = r.mem_addr;
      default:                mapped   = 1'b0;
    endcase
  end

  // ==========================================================
  // Next state
  always_comb begin
    next_r = r;

    // Read data and error are caught while psel stands, so the
    // access phase answers from flops with no wait when ce is high
    if (psel && ce) begin
      next_r.captured = ~acc_phase;
      if (!penable || !r.captured) begin
        next_r.prdata  = read_mux;
        next_r.pslverr = ~mapped;
      end
    end else if (!psel) begin
      next_r.captured = 1'b0;
    end

    // Configuration is owned by the engine while busy
    if (wr_en && !is_busy) begin
      case (paddr)
        xscm_pkg::OFF_CTRL: begin
          next_r.op      = pwdata[xscm_pkg::CTRL_OP_LSB +: 2];
          next_r.cond    = pwdata[xscm_pkg::CTRL_COND_LSB +: 4];
          next_r.mem_sel = pwdata[xscm_pkg::CTRL_MEM_BIT];
        end
        xscm_pkg::OFF_OPA:      next_r.opa      = pwdata;
        xscm_pkg::OFF_OPB:      next_r.opb      = pwdata;
        xscm_pkg::OFF_FLAGS:    next_r.flags    = pwdata;
        xscm_pkg::OFF_MEM_ADDR: next_r.mem_addr = pwdata;
        default: ;
      endcase
    end

    // Done is write-one-to-clear; completion below overrides
    if (wr_en && paddr == xscm_pkg::OFF_STATUS && pwdata[xscm_pkg::ST_DONE_BIT]) begin
      next_r.done = 1'b0;
    end

    case (r.fsm)
      xscm_pkg::ST_IDLE: begin
        if (wr_en && paddr == xscm_pkg::OFF_CMD && pwdata[xscm_pkg::CMD_START_BIT]) begin
          next_r.fsm       = xscm_pkg::ST_EXEC;
          next_r.done      = 1'b0;
          next_r.cond_true = 1'b0;
          next_r.moved     = 1'b0;
        end
      end

      xscm_pkg::ST_EXEC: begin
        next_r.fsm  = xscm_pkg::ST_IDLE;
        next_r.done = 1'b1;
        case (r.op)
          xscm_pkg::OP_EXCHANGE: begin
            if (r.mem_sel) begin
              // Lock rises with the read and holds through the write
              next_r.fsm       = xscm_pkg::ST_MEM_READ;
              next_r.done      = 1'b0;
              next_r.mem.req   = 1'b1;
              next_r.mem.we    = 1'b0;
              next_r.mem.lock  = 1'b1;
              next_r.mem.addr  = r.mem_addr;
              next_r.mem.wdata = r.opa;
            end else begin
              next_r.opa = r.opb;
              next_r.opb = r.opa;
            end
          end
          xscm_pkg::OP_BYTE_REVERSE: begin
            next_r.opa = reversed;
          end
          xscm_pkg::OP_COND_MOVE: begin
            next_r.cond_true = cond_hit;
            next_r.moved     = cond_hit;
            // False condition: destination untouched, op still completes
            if (cond_hit) begin
              next_r.opa = r.opb;
            end
          end
          xscm_pkg::OP_WORD_BYTE_EXCH: begin
            next_r.opa = {r.opa[31:16], r.opa[7:0], r.opa[15:8]};
          end
          default: ;
        endcase
      end

      xscm_pkg::ST_MEM_READ: begin
        if (mem_ack) begin
          next_r.tmp    = mem_rdata;
          next_r.mem.we = 1'b1;
          next_r.fsm    = xscm_pkg::ST_MEM_WRITE;
        end
      end

      xscm_pkg::ST_MEM_WRITE: begin
        if (mem_ack) begin
          next_r.opa      = r.tmp;
          next_r.mem.req  = 1'b0;
          next_r.mem.we   = 1'b0;
          next_r.mem.lock = 1'b0;
          next_r.done     = 1'b1;
          next_r.fsm      = xscm_pkg::ST_IDLE;
        end
      end

      default: next_r.fsm = xscm_pkg::ST_IDLE;
    endcase
  end

  // ==========================================================
  // State register; ce low freezes everything
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r.fsm       <= xscm_pkg::ST_IDLE;
      r.op        <= xscm_pkg::RST_OP;
      r.cond      <= xscm_pkg::RST_COND;
      r.mem_sel   <= 1'b0;
      r.opa       <= xscm_pkg::RST_WORD;
      r.opb       <= xscm_pkg::RST_WORD;
      r.flags     <= xscm_pkg::RST_WORD;
      r.mem_addr  <= xscm_pkg::RST_WORD;
      r.tmp       <= xscm_pkg::RST_WORD;
      r.done      <= 1'b0;
      r.cond_true <= 1'b0;
      r.moved     <= 1'b0;
      r.mem.req   <= 1'b0;
      r.mem.we    <= 1'b0;
      r.mem.lock  <= 1'b0;
      r.mem.addr  <= xscm_pkg::RST_WORD;
      r.mem.wdata <= xscm_pkg::RST_WORD;
      r.prdata    <= xscm_pkg::RST_WORD;
      r.pslverr   <= 1'b0;
      r.captured  <= 1'b0;
    end else if (ce) begin
      r <= next_r;
    end
  end

  // ==========================================================
  // Outputs
  assign prdata    = r.prdata;
  assign pslverr   = r.pslverr & acc_phase;
  assign pready    = acc_phase;
  assign mem_req   = r.mem.req;
  assign mem_we    = r.mem.we;
  assign mem_lock  = r.mem.lock;
  assign mem_addr  = r.mem.addr[ADDR_W-1:0];
  assign mem_wdata = r.mem.wdata;
  assign busy      = is_busy;

endmodule : xscm_unit

// ==== rtl/xscm_pkg.sv ====
package xscm_pkg;

  // ==========================================================
  // Register offsets (byte addresses on APB)
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_CMD      = 8'h04;
  localparam logic [7:0] OFF_STATUS   = 8'h08;
  localparam logic [7:0] OFF_OPA      = 8'h0C;
  localparam logic [7:0] OFF_OPB      = 8'h10;
  localparam logic [7:0] OFF_FLAGS    = 8'h14;
  localparam logic [7:0] OFF_MEM_ADDR = 8'h18;

  // ==========================================================
  // Field positions
  localparam int CTRL_OP_LSB   = 0;
  localparam int CTRL_COND_LSB = 4;
  localparam int CTRL_MEM_BIT  = 8;
  localparam int CMD_START_BIT = 0;
  localparam int ST_BUSY_BIT   = 0;
  localparam int ST_DONE_BIT   = 1;
  localparam int ST_COND_BIT   = 2;
  localparam int ST_MOVED_BIT  = 3;
  localparam int ST_LOCK_BIT   = 4;

  // Status flag positions inside flag_register
  localparam int CARRY_BIT    = 0;
  localparam int PARITY_BIT   = 2;
  localparam int ZERO_BIT     = 6;
  localparam int SIGN_BIT     = 7;
  localparam int OVERFLOW_BIT = 11;

  // ==========================================================
  // Reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [1:0]  RST_OP   = 2'h0;
  localparam logic [3:0]  RST_COND = 4'h0;

  // ==========================================================
  // Operation codes
  localparam logic [1:0] OP_EXCHANGE      = 2'h0;
  localparam logic [1:0] OP_BYTE_REVERSE  = 2'h1;
  localparam logic [1:0] OP_COND_MOVE     = 2'h2;
  localparam logic [1:0] OP_WORD_BYTE_EXCH = 2'h3;

  // Condition codes for conditional_move
  localparam logic [3:0] CC_ABOVE       = 4'h0;
  localparam logic [3:0] CC_ABOVE_EQ    = 4'h1;
  localparam logic [3:0] CC_BELOW       = 4'h2;
  localparam logic [3:0] CC_BELOW_EQ    = 4'h3;
  localparam logic [3:0] CC_EQUAL       = 4'h4;
  localparam logic [3:0] CC_NOT_EQUAL   = 4'h5;
  localparam logic [3:0] CC_PARITY_EVEN = 4'h6;
  localparam logic [3:0] CC_PARITY_ODD  = 4'h7;
  localparam logic [3:0] CC_GREATER_EQ  = 4'h8;
  localparam logic [3:0] CC_LESS        = 4'h9;
  localparam logic [3:0] CC_LESS_EQ     = 4'hA;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_EXEC,
    ST_MEM_READ,
    ST_MEM_WRITE
  } xscm_fsm_t;

  typedef struct packed {
    logic carry_flag;
    logic zero_flag;
    logic parity_flag;
    logic sign_flag;
    logic overflow_flag;
  } xscm_flags_t;

  typedef struct packed {
    logic        req;
    logic        we;
    logic        lock;
    logic [31:0] addr;
    logic [31:0] wdata;
  } xscm_mem_t;

  typedef struct packed {
    xscm_fsm_t   fsm;
    logic [1:0]  op;
    logic [3:0]  cond;
    logic        mem_sel;
    logic [31:0] opa;
    logic [31:0] opb;
    logic [31:0] flags;
    logic [31:0] mem_addr;
    logic [31:0] tmp;
    logic        done;
    logic        cond_true;
    logic        moved;
    xscm_mem_t   mem;
    logic [31:0] prdata;
    logic        pslverr;
    logic        captured;
  } xscm_state_t;

endpackage : xscm_pkg

// ==== rtl/xscm_cond_eval.sv ====
`timescale 1ns/100ps

module xscm_cond_eval (
  input  wire xscm_pkg::xscm_flags_t flags,
  input  wire logic [3:0]            cond,
  output logic                       cond_true
);

  logic cf;
  logic zf;
  logic pf;
  logic sof;

  assign cf  = flags.carry_flag;
  assign zf  = flags.zero_flag;
  assign pf  = flags.parity_flag;
  assign sof = flags.sign_flag ^ flags.overflow_flag;

  // ==========================================================
  // Condition table; unlisted codes never move
  always_comb begin
    case (cond)
      xscm_pkg::CC_ABOVE:       cond_true = ~(cf | zf);
      xscm_pkg::CC_ABOVE_EQ:    cond_true = ~cf;
      xscm_pkg::CC_BELOW:       cond_true = cf;
      xscm_pkg::CC_BELOW_EQ:    cond_true = cf | zf;
      xscm_pkg::CC_EQUAL:       cond_true = zf;
      xscm_pkg::CC_NOT_EQUAL:   cond_true = ~zf;
      xscm_pkg::CC_PARITY_EVEN: cond_true = pf;
      xscm_pkg::CC_PARITY_ODD:  cond_true = ~pf;
      xscm_pkg::CC_GREATER_EQ:  cond_true = ~sof;
      xscm_pkg::CC_LESS:        cond_true = sof;
      xscm_pkg::CC_LESS_EQ:     cond_true = sof | zf;
      default:                  cond_true = 1'b0;
    endcase
  end

endmodule : xscm_cond_eval

// ==== bench/xscm_unit_asserts.sv ====
`timescale 1ns/100ps

module xscm_unit_asserts #(
  parameter int ADDR_W = 32
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              ce,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [7:0]        paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              mem_req,
  input wire logic              mem_we,
  input wire logic              mem_lock,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic [31:0]       mem_wdata,
  input wire logic [31:0]       mem_rdata,
  input wire logic              mem_ack,
  input wire logic              busy
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ==========================================================
  // Locked memory exchange
  AST_LOCK_WITH_REQ: assert property (mem_req |-> mem_lock)
    else $error("lock low during memory access");
  AST_NO_LOCK_IDLE: assert property (mem_lock |-> mem_req)
    else $error("lock high without an access");
  AST_REQ_HELD: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
    else $error("request dropped before ack");
  AST_READ_THEN_WRITE: assert property (ce && mem_req && !mem_we && mem_ack
    |=> mem_we && mem_lock)
    else $error("read ack not followed by locked write");
  AST_WRITE_OLD_OPA: assert property (mem_req && !mem_we ##1 mem_req |-> $stable(mem_wdata))
    else $error("write data changed during exchange");
  AST_END_AFTER_WRITE: assert property (ce && mem_req && mem_we && mem_ack
    |=> !mem_req && !busy)
    else $error("exchange did not end after write ack");
  AST_REQ_IN_BUSY: assert property (mem_req |-> busy)
    else $error("memory request while idle");
  // Register ops finish in one busy cycle
  AST_REG_OP_SHORT: assert property (busy && !mem_req && ce |=> mem_req || !busy)
    else $error("register operation overran");
  // Clock enable low holds busy, request and lock, and refuses transfers
  AST_CE_FREEZE: assert property (!ce |-> !pready ##1
    ($stable(busy) && $stable(mem_req) && $stable(mem_lock)))
    else $error("state moved while clock enable low");
endmodule : xscm_unit_asserts

bind xscm_unit xscm_unit_asserts #(.ADDR_W(ADDR_W)) xscm_unit_asserts_inst (
  .pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
  .pslverr, .mem_req, .mem_we, .mem_lock, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack, .busy);

// ==== bench/xscm_mem_model.sv ====
`timescale 1ns/100ps

module xscm_mem_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [3:0]  delay,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [31:0] mem_addr,
  input  wire logic [31:0] mem_wdata,
  output logic      [31:0] mem_rdata,
  output logic             mem_ack
);
  logic [31:0] mem [0:15];
  logic [3:0]  cnt;

  // Read data only valid with ack; toggles otherwise so stale use shows
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt       <= 4'h0;
      mem_ack   <= 1'b0;
      mem_rdata <= 32'h0000_0000;
    end else begin
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack) begin
        if (cnt == delay) begin
          mem_ack <= 1'b1;
          cnt     <= 4'h0;
          if (mem_we) mem[mem_addr[5:2]] <= mem_wdata;
          else mem_rdata <= mem[mem_addr[5:2]];
        end else begin
          cnt <= cnt + 4'h1;
        end
      end
    end
  end
endmodule : xscm_mem_model

// ==== bench/exchange_swap_cond_move_unit_test.sv ====
`timescale 1ns/100ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
  $display("unexpected at %0t: got %h exp %h", $time, (g), (e)); end end

module exchange_swap_cond_move_unit_test;
  localparam logic [31:0] A = 32'h1122_3344;
  localparam logic [31:0] B = 32'h5566_7788;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, st, mem_addr, mem_wdata, mem_rdata, eo, eb;
  logic        pready, pslverr, err, mem_req, mem_we, mem_lock, mem_ack, busy, ec;
  logic        ce = 1'b1;
  logic [3:0]  delay = 4'h0, cond;
  logic [1:0]  op;
  logic [11:0] flg;
  int          mismatches = 0, n_tests = 0, cycles = 0;
  // Rows: op, cond, flags, expected condition outcome
  logic [18:0] rows [22] = '{{2'h0,4'h0,12'h000,1'b0}, {2'h1,4'h0,12'h000,1'b0},
    {2'h3,4'h0,12'h000,1'b0}, {2'h2,4'h0,12'h000,1'b1}, {2'h2,4'h0,12'h001,1'b0},
    {2'h2,4'h0,12'h040,1'b0}, {2'h2,4'h1,12'h000,1'b1}, {2'h2,4'h1,12'h001,1'b0},
    {2'h2,4'h2,12'h001,1'b1}, {2'h2,4'h2,12'h000,1'b0}, {2'h2,4'h3,12'h040,1'b1},
    {2'h2,4'h3,12'h000,1'b0}, {2'h2,4'h4,12'h040,1'b1}, {2'h2,4'h5,12'h040,1'b0},
    {2'h2,4'h6,12'h004,1'b1}, {2'h2,4'h7,12'h004,1'b0}, {2'h2,4'h8,12'h880,1'b1},
    {2'h2,4'h8,12'h080,1'b0}, {2'h2,4'h9,12'h800,1'b1}, {2'h2,4'hA,12'h040,1'b1},
    {2'h2,4'hA,12'h880,1'b0}, {2'h2,4'hB,12'h8C5,1'b0}};

  xscm_unit xscm_unit_inst (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mem_req(mem_req), .mem_we(mem_we),
    .mem_lock(mem_lock), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack), .busy(busy));
  xscm_mem_model xscm_mem_model_inst (.pclk(pclk), .presetn(presetn), .delay(delay),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack));

  initial begin
    forever #50 pclk = ~pclk;
  end

  // ==========================================================
  // Hang guard
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 6000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic start_op(input logic [1:0] o, input logic [3:0] c, input logic m,
                          input logic [11:0] f, input logic [31:0] a, input logic [31:0] b);
    apb(1'b1, xscm_pkg::OFF_FLAGS, {20'h0, f});
    apb(1'b1, xscm_pkg::OFF_OPA, a);
    apb(1'b1, xscm_pkg::OFF_OPB, b);
    apb(1'b1, xscm_pkg::OFF_CTRL, {23'h0, m, c, 2'h0, o});
    apb(1'b1, xscm_pkg::OFF_CMD, 32'h0000_0001);
  endtask : start_op

  task automatic wait_done();
    st = 32'h0;
    for (int k = 0; k < 40 && st[xscm_pkg::ST_DONE_BIT] !== 1'b1; k++) begin
      apb(1'b0, xscm_pkg::OFF_STATUS, 32'h0);
      st = rd;
    end
    `CHK(st[xscm_pkg::ST_DONE_BIT], 1'b1)
  endtask : wait_done

  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    // ==========================================================
    // Table of register operations
    foreach (rows[i]) begin
      {op, cond, flg, ec} = rows[i];
      start_op(op, cond, 1'b0, flg, A, B);
      wait_done();
      eb = B;
      case (op)
        xscm_pkg::OP_EXCHANGE:     {eo, eb} = {B, A};
        xscm_pkg::OP_BYTE_REVERSE: eo = {A[7:0], A[15:8], A[23:16], A[31:24]};
        xscm_pkg::OP_COND_MOVE:    eo = ec ? B : A;
        default:                   eo = {A[31:16], A[7:0], A[15:8]};
      endcase
      if (op == xscm_pkg::OP_COND_MOVE) `CHK(st[3:2], {ec, ec})
      apb(1'b0, xscm_pkg::OFF_OPA, 32'h0);
      `CHK(rd, eo)
      apb(1'b0, xscm_pkg::OFF_OPB, 32'h0);
      `CHK(rd, eb)
    end
    $display("test table done");
    // Two byte reverses in a row
    start_op(xscm_pkg::OP_BYTE_REVERSE, 4'h0, 1'b0, 12'h000, A, B);
    wait_done();
    apb(1'b1, xscm_pkg::OFF_CMD, 32'h0000_0001);
    wait_done();
    apb(1'b0, xscm_pkg::OFF_OPA, 32'h0);
    `CHK(rd, A)
    $display("test double reverse done");
    // Locked memory exchange, slow memory, write while busy must be ignored
    delay <= 4'h5;
    xscm_mem_model_inst.mem[2] = 32'hCAFE_0001;
    apb(1'b1, xscm_pkg::OFF_MEM_ADDR, 32'h0000_0008);
    start_op(xscm_pkg::OP_EXCHANGE, 4'h0, 1'b1, 12'h000, A, B);
    apb(1'b1, xscm_pkg::OFF_OPB, 32'hDEAD_BEEF);
    apb(1'b0, xscm_pkg::OFF_STATUS, 32'h0);
    `CHK({rd[xscm_pkg::ST_BUSY_BIT], rd[xscm_pkg::ST_LOCK_BIT]}, 2'h3)
    wait_done();
    `CHK(st[xscm_pkg::ST_LOCK_BIT], 1'b0)
    apb(1'b0, xscm_pkg::OFF_OPA, 32'h0);
    `CHK(rd, 32'hCAFE_0001)
    `CHK(xscm_mem_model_inst.mem[2], A)
    apb(1'b0, xscm_pkg::OFF_OPB, 32'h0);
    `CHK(rd, B)
    $display("test memory exchange done");
    // Done clears on write-one, unmapped address errors
    apb(1'b1, xscm_pkg::OFF_STATUS, 32'h0000_0002);
    apb(1'b0, xscm_pkg::OFF_STATUS, 32'h0);
    `CHK(rd[xscm_pkg::ST_DONE_BIT], 1'b0)
    apb(1'b0, 8'h1C, 32'h0);
    `CHK({err, rd}, {1'b1, 32'h0})
    $display("test status and error done");
    // Clock enable low freezes a started byte reverse
    start_op(xscm_pkg::OP_BYTE_REVERSE, 4'h0, 1'b0, 12'h000, A, B);
    ce <= 1'b0;
    repeat (4) @(posedge pclk);
    `CHK(busy, 1'b1)
    ce <= 1'b1;
    wait_done();
    apb(1'b0, xscm_pkg::OFF_OPA, 32'h0);
    `CHK(rd, {A[7:0], A[15:8], A[23:16], A[31:24]})
    $display("test clock enable done");
    // Reset in the middle of a locked access
    start_op(xscm_pkg::OP_EXCHANGE, 4'h0, 1'b1, 12'h000, A, B);
    repeat (3) @(posedge pclk);
    `CHK({mem_req, mem_lock}, 2'h3)
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    `CHK({busy, mem_req, mem_lock}, 3'h0)
    presetn <= 1'b1;
    apb(1'b0, xscm_pkg::OFF_OPA, 32'h0);
    `CHK(rd, xscm_pkg::RST_WORD)
    apb(1'b0, xscm_pkg::OFF_CTRL, 32'h0);
    `CHK(rd, xscm_pkg::RST_WORD)
    $display("test mid run reset done");
    tally_and_finish();
  end
endmodule : exchange_swap_cond_move_unit_test
